// *** sarseq_top.sv ***
`timescale 1ns/1ps
module sarseq_top
    import sarseq_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              cs_n,
    input  wire logic              wr_n,
    input  wire logic              rd_n,
    input  wire logic              cal_n,
    input  wire logic              offset_null_select_n,
    input  wire logic              comp_high,
    output      logic [RES_W-1:0]  result_bus_out,
    output      logic [RES_W-1:0]  result_bus_oe_n,
    output      logic              ready_flag,
    output      logic              done_n,
    output      logic [MAG_W-1:0]  dac_code,
    output      logic              dac_sign,
    output      logic [CORR_W-1:0] trim_word,
    output      logic              sample_en,
    output      logic              offset_meas_en,
    output      logic              ladder_meas_en
);

    sarseq_host_s      raw;
    sarseq_host_s      syn;
    sarseq_host_s      prev_r;
    sarseq_state_e     state_r;
    sarseq_state_e     state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [3:0]        idx_r;
    logic [3:0]        idx_nxt;
    logic [DIV_W-1:0]  div_r;
    logic              tick_r;
    logic [RES_W-1:0]  sar_r;
    logic [RES_W-1:0]  result_r;
    logic [RES_W-1:0]  result_out_r;
    logic [RES_W-1:0]  result_oe_n_r;
    logic              ready_r;
    logic              done_n_r;
    logic [CORR_W-1:0] ofs_corr_r;
    logic [CORR_W-1:0] acc_r;
    logic [6:0]        slot_cnt_r;
    logic [3:0]        slot_idx_r;
    logic [CORR_W-1:0] corr_mem [CORR_N];
    logic [CORR_W-1:0] trim_r;
    logic              sample_r;
    logic              ofs_meas_r;
    logic              lad_meas_r;
    logic              cal_busy;
    logic              cal_req;
    logic              conv_reset;
    logic              wr_start;
    logic              abort;
    logic              finish;
    logic              reading;
    logic              test_mode;

    function automatic logic is_cal(input sarseq_state_e s);
        is_cal = (s == ST_CAL_OFS) || (s == ST_CAL_LAD);
    endfunction : is_cal

    function automatic logic is_last(input logic [CNT_W-1:0] c,
                                     input logic [CNT_W-1:0] len);
        is_last = (c == len - 11'h001);
    endfunction : is_last

    function automatic logic [CORR_W-1:0] step(input logic [CORR_W-1:0] a,
                                               input logic up);
        step = up ? a + 8'h01 : a - 8'h01;
    endfunction : step

    assign raw = '{cs_n: cs_n, wr_n: wr_n, rd_n: rd_n, cal_n: cal_n,
                   az_n: offset_null_select_n};

    sarseq_sync u_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .raw    (raw),
        .synced (syn)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= HOST_IDLE;
        end else begin
            prev_r <= syn;
        end
    end

    // The converter clock is a tick pulse; the ratio keeps it in the legal range.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r == DIV_LAST);
            div_r  <= (div_r == DIV_LAST) ? '0 : div_r + 5'h01;
        end
    end

    assign cal_busy   = is_cal(state_r);
    assign cal_req    = !syn.cal_n;
    assign conv_reset = !syn.cs_n && !syn.wr_n;
    assign wr_start   = !prev_r.wr_n && syn.wr_n && !prev_r.cs_n;
    assign abort      = cal_req || conv_reset || wr_start;
    assign finish     = (state_r == ST_SAR) && tick_r && !abort && (idx_r == 4'h0);
    assign reading    = !syn.cs_n && !syn.rd_n;
    assign test_mode  = !syn.cs_n && !syn.cal_n && syn.rd_n;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        idx_nxt   = idx_r;
        if (cal_busy) begin
            if (tick_r) begin
                cnt_nxt = cnt_r + 11'h001;
                if (is_last(cnt_r, CAL_TICKS)) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = '0;
                end else if (is_last(cnt_r, CAL_OFS_TICKS)) begin
                    state_nxt = ST_CAL_LAD;
                end
            end
        end else if (cal_req) begin
            state_nxt = ST_CAL_OFS;
            cnt_nxt   = '0;
        end else if (conv_reset) begin
            state_nxt = ST_IDLE;
            cnt_nxt   = '0;
        end else if (wr_start) begin
            state_nxt = syn.az_n ? ST_SAMPLE : ST_AZ;
            cnt_nxt   = '0;
        end else if (tick_r) begin
            case (state_r)
                ST_AZ: begin
                    cnt_nxt = cnt_r + 11'h001;
                    if (is_last(cnt_r, AZ_TICKS)) begin
                        state_nxt = ST_SAMPLE;
                        cnt_nxt   = '0;
                    end
                end
                ST_SAMPLE: begin
                    cnt_nxt = cnt_r + 11'h001;
                    if (is_last(cnt_r, SAMPLE_TICKS)) begin
                        state_nxt = ST_SAR;
                        cnt_nxt   = '0;
                        idx_nxt   = SIGN_IDX;
                    end
                end
                ST_SAR: begin
                    if (idx_r == 4'h0) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        idx_nxt = idx_r - 4'h1;
                    end
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    // Power-up enters calibration straight from reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_CAL_OFS;
            cnt_r   <= '0;
            idx_r   <= SIGN_IDX;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            idx_r   <= idx_nxt;
        end
    end

    // Approximation register: sign step, then one trial bit per tick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sar_r <= RESULT_RST;
        end else if (state_r != ST_SAR && state_nxt == ST_SAR) begin
            sar_r <= RESULT_RST;
        end else if (state_r == ST_SAR && tick_r && !abort) begin
            if (idx_r == SIGN_IDX) begin
                sar_r[RES_W-1] <= !comp_high;
                sar_r[MAG_W-1] <= 1'b1;
            end else begin
                sar_r[idx_r] <= comp_high;
                if (idx_r != 4'h0) begin
                    sar_r[idx_r - 4'h1] <= 1'b1;
                end
            end
        end
    end

    // Output latch keeps sign in bit 12 and magnitude below it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= RESULT_RST;
        end else if (finish) begin
            result_r <= {sar_r[RES_W-1:1], comp_high};
        end
    end

    // Offset correction from calibration and from each null cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ofs_corr_r <= CORR_RST;
        end else if (tick_r && (state_r == ST_CAL_OFS || state_r == ST_AZ)) begin
            ofs_corr_r <= step(ofs_corr_r, comp_high);
        end
    end

    // Ladder mismatch: one correction word per magnitude bit.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_r      <= CORR_RST;
            slot_cnt_r <= '0;
            slot_idx_r <= '0;
        end else if (state_r != ST_CAL_LAD) begin
            acc_r      <= CORR_RST;
            slot_cnt_r <= '0;
            slot_idx_r <= '0;
        end else if (tick_r) begin
            if (slot_cnt_r == LAD_SLOT_TICKS - 7'h01) begin
                acc_r      <= CORR_RST;
                slot_cnt_r <= '0;
                slot_idx_r <= slot_idx_r + 4'h1;
            end else begin
                acc_r      <= step(acc_r, comp_high);
                slot_cnt_r <= slot_cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (state_r == ST_CAL_LAD && tick_r && slot_cnt_r == LAD_SLOT_TICKS - 7'h01
            && slot_idx_r < SIGN_IDX) begin
            corr_mem[slot_idx_r] <= step(acc_r, comp_high);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trim_r     <= CORR_RST;
            sample_r   <= 1'b0;
            ofs_meas_r <= 1'b1;
            lad_meas_r <= 1'b0;
        end else begin
            trim_r     <= (state_r == ST_SAR && idx_r < SIGN_IDX) ? corr_mem[idx_r]
                                                                  : ofs_corr_r;
            sample_r   <= (state_nxt == ST_SAMPLE);
            ofs_meas_r <= (state_nxt == ST_CAL_OFS) || (state_nxt == ST_AZ);
            lad_meas_r <= (state_nxt == ST_CAL_LAD);
        end
    end

    // Busy is low through calibration and approximation only.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= !(is_cal(state_nxt) || state_nxt == ST_SAR);
        end
    end

    // Completion flag: finishing wins over a read clear in the same cycle; an abort blocks finishing, so its clear wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_n_r <= 1'b1;
        end else if (finish) begin
            done_n_r <= 1'b0;
        end else if (reading || conv_reset || wr_start || (cal_req && !cal_busy)) begin
            done_n_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_out_r  <= RESULT_RST;
            result_oe_n_r <= OE_OFF;
        end else if (reading) begin
            result_out_r  <= result_r;
            result_oe_n_r <= '0;
        end else if (test_mode) begin
            result_out_r  <= sar_r & TEST_MASK;
            result_oe_n_r <= ~TEST_MASK;
        end else begin
            result_out_r  <= result_r;
            result_oe_n_r <= OE_OFF;
        end
    end

    assign result_bus_out  = result_out_r;
    assign result_bus_oe_n = result_oe_n_r;
    assign ready_flag      = ready_r;
    assign done_n          = done_n_r;
    assign dac_code        = sar_r[MAG_W-1:0];
    assign dac_sign        = sar_r[RES_W-1];
    assign trim_word       = trim_r;
    assign sample_en       = sample_r;
    assign offset_meas_en  = ofs_meas_r;
    assign ladder_meas_en  = lad_meas_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_start_cs_gate: assert property (
        (state_r == ST_IDLE && (state_nxt == ST_AZ || state_nxt == ST_SAMPLE))
        |-> (!prev_r.cs_n && !prev_r.wr_n && syn.wr_n))
        else $error("conversion started without chip select and write edge");
    a_read_drive: assert property (
        (reading && !finish) |=> (result_oe_n_r == '0 && result_out_r == $past(result_r)
                                  && done_n_r))
        else $error("read did not drive bus or clear completion");
    a_cal_request: assert property (
        (cal_req && !cal_busy) |=> (state_r == ST_CAL_OFS && cnt_r == '0))
        else $error("calibration request did not start calibration");
    a_cal_busy_low: assert property (
        cal_busy |-> !ready_r)
        else $error("busy flag high during calibration");
    a_cal_length: assert property (
        (cal_busy && !is_cal(state_nxt)) |-> (cnt_r == CAL_TICKS - 11'h001 && tick_r))
        else $error("calibration ended at wrong count");
    a_cal_hold: assert property (
        (cal_busy && !(tick_r && is_last(cnt_r, CAL_TICKS))) |=> is_cal(state_r))
        else $error("calibration interrupted");
    a_null_select: assert property (
        (state_r == ST_AZ && state_nxt == ST_SAMPLE) |-> cnt_r == AZ_TICKS - 11'h001)
        else $error("offset-null cycle has wrong length");
    a_sample_len: assert property (
        (state_r == ST_SAMPLE && state_nxt == ST_SAR)
        |-> (cnt_r == SAMPLE_TICKS - 11'h001) ##1 !ready_r)
        else $error("sampling length or busy edge wrong");
    a_sign_step: assert property (
        (state_r == ST_SAR && tick_r && !abort && idx_r == SIGN_IDX)
        |=> (sar_r[RES_W-1] == !$past(comp_high) && sar_r[MAG_W-1]))
        else $error("sign step wrong");
    a_bit_trial: assert property (
        (state_r == ST_SAR && tick_r && !abort && idx_r < SIGN_IDX)
        |=> sar_r[$past(idx_r)] == $past(comp_high))
        else $error("magnitude bit not kept per comparator");
    a_done_latch: assert property (
        finish |=> (!done_n_r && ready_r && result_r[RES_W-1] == $past(sar_r[RES_W-1])))
        else $error("completion not signalled with latched result");
    a_test_drive: assert property (
        (test_mode && !reading) |=> result_oe_n_r == ~TEST_MASK)
        else $error("test mode drive wrong");
    a_abort_conv: assert property (
        (conv_reset && !cal_busy && !cal_req) |=> state_r == ST_IDLE)
        else $error("write low did not abort conversion");

    c_conv_done:  cover property (finish);
    c_az_conv:    cover property (state_r == ST_AZ ##1 state_r == ST_AZ);
    c_cal_end:    cover property (cal_busy ##1 !cal_busy);
    c_read_after: cover property (!done_n_r && reading);

endmodule : sarseq_top

// *** sarseq_pkg.sv ***
package sarseq_pkg;

    // System clock and the converter clock derived from it by a tick divider.
    localparam int SYS_CLK_HZ  = 50_000_000;
    localparam int CONV_CLK_HZ = 2_000_000;
    localparam int CONV_MIN_HZ = 500_000;
    localparam int CONV_MAX_HZ = 4_000_000;
    localparam int DIV_RATIO   = SYS_CLK_HZ / CONV_CLK_HZ;

    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);

    // Phase lengths in converter clock periods.
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] CAL_TICKS     = 11'h574;
    localparam logic [CNT_W-1:0] CAL_OFS_TICKS = 11'h064;
    localparam logic [CNT_W-1:0] AZ_TICKS      = 11'h01a;
    localparam logic [CNT_W-1:0] SAMPLE_TICKS  = 11'h007;
    localparam logic [6:0]       LAD_SLOT_TICKS = 7'h6c;

    // Result word layout.
    localparam int RES_W = 13;
    localparam int MAG_W = 12;
    localparam logic [3:0] SIGN_IDX = 4'hc;
    localparam logic [RES_W-1:0] RESULT_RST = 13'h0000;
    localparam logic [RES_W-1:0] TEST_MASK  = 13'h006c;
    localparam logic [RES_W-1:0] OE_OFF     = 13'h1fff;

    // Correction memory.
    localparam int CORR_W = 8;
    localparam int CORR_N = 12;
    localparam logic [CORR_W-1:0] CORR_RST = 8'h00;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic cal_n;
        logic az_n;
    } sarseq_host_s;

    localparam sarseq_host_s HOST_IDLE = 5'h1f;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_CAL_OFS = 3'b001,
        ST_CAL_LAD = 3'b010,
        ST_AZ      = 3'b011,
        ST_SAMPLE  = 3'b100,
        ST_SAR     = 3'b101
    } sarseq_state_e;

endpackage : sarseq_pkg

// *** sarseq_sync.sv ***
`timescale 1ns/1ps
module sarseq_sync
    import sarseq_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire sarseq_host_s raw,
    output      sarseq_host_s synced
);

    sarseq_host_s meta_r;

    // Two flip-flops per strobe; the first is read only by the second.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= HOST_IDLE;
            synced <= HOST_IDLE;
        end else begin
            meta_r <= raw;
            synced <= meta_r;
        end
    end

endmodule : sarseq_sync

// *** sarseq_host_model.sv ***
`timescale 1ns/1ps
module sarseq_host_model
    import sarseq_pkg::*;
(
    input  wire logic             clock,
    input  wire logic [RES_W-1:0] bus_out,
    input  wire logic [RES_W-1:0] bus_oe_n,
    output      sarseq_host_s     pins
);
    initial pins = HOST_IDLE;

    // Applies a pin pattern and holds it for n falling edges.
    task drive(input sarseq_host_s v, input int n);
        pins = v;
        repeat (n) @(negedge clock);
    endtask : drive

    task start(input logic az);
        drive({1'h0, 1'h0, 1'h1, 1'h1, az}, 5);
        drive({1'h0, 1'h1, 1'h1, 1'h1, az}, 3);
        drive({1'h1, 1'h1, 1'h1, 1'h1, az}, 1);
    endtask : start

    task cal_pulse();
        drive({1'h1, 1'h1, 1'h1, 1'h0, 1'h1}, 5);
        drive(HOST_IDLE, 1);
    endtask : cal_pulse

    task read(output logic [RES_W-1:0] d, output logic ok);
        logic az;
        az = pins.az_n;
        d = 13'h0000;
        ok = 1'h0;
        drive({1'h0, 1'h1, 1'h0, 1'h1, az}, 1);
        for (int i = 0; i < 10 && !ok; i++) begin
            if (bus_oe_n === 13'h0000) begin
                ok = 1'h1;
                d = bus_out;
            end else begin
                @(negedge clock);
            end
        end
        drive({1'h1, 1'h1, 1'h1, 1'h1, az}, 1);
    endtask : read
endmodule : sarseq_host_model

// *** sarseq_tb.sv ***
`timescale 1ns/1ps
module tb
    import sarseq_pkg::*;
();
    logic             clock;
    logic             rst_n;
    logic             comp_high;
    logic [RES_W-1:0] vin;
    sarseq_host_s     pins;
    logic [RES_W-1:0] bus_out;
    logic [RES_W-1:0] bus_oe_n;
    logic             ready_flag;
    logic             done_n;
    logic             dac_sign;
    logic [MAG_W-1:0] dac_code;
    logic             sample_en;
    logic             offs_en;
    logic             lad_en;
    logic [CORR_W-1:0] trim;
    logic [RES_W-1:0] d;
    logic             ok;
    int               n_mismatch;
    int               tests_run;
    int               n;
    time              t0;
    logic [RES_W-1:0] vals [5] = '{13'h0abc, 13'h1fff, 13'h1000, 13'h0fff, 13'h0000};

    sarseq_host_model sarseq_host_model_i (.clock(clock), .bus_out(bus_out),
        .bus_oe_n(bus_oe_n), .pins(pins));

    sarseq_top sarseq_top_i (.clock(clock), .rst_n(rst_n), .cs_n(pins.cs_n),
        .wr_n(pins.wr_n), .rd_n(pins.rd_n), .cal_n(pins.cal_n),
        .offset_null_select_n(pins.az_n), .comp_high(comp_high),
        .result_bus_out(bus_out), .result_bus_oe_n(bus_oe_n), .ready_flag(ready_flag),
        .done_n(done_n), .dac_code(dac_code), .dac_sign(dac_sign), .trim_word(trim),
        .sample_en(sample_en), .offset_meas_en(offs_en), .ladder_meas_en(lad_en));

    always #10 clock = ~clock;

    // Comparator: against ground while no trial bit is set, else against the trial code.
    always @(negedge clock) begin
        if (dac_code === 12'h000) begin
            comp_high <= ($signed(vin) >= $signed(13'h0000));
        end else begin
            comp_high <= ($signed(vin) >= $signed({dac_sign, dac_code}));
        end
    end

    task results();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task chk(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task tend(input string name);
        $display("test %s finished", name);
    endtask : tend

    function automatic logic in_rng(input int v, input int lo, input int hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_rng

    function automatic int since(input time t);
        return int'(($time - t) / 20);
    endfunction : since

    // Waits on a selected flag for a level, counting falling edges.
    task wait_sig(input int s, input logic lv, input int lim, output int cnt);
        logic v;
        for (cnt = 0; cnt < lim; cnt++) begin
            case (s)
                0: v = ready_flag;
                1: v = done_n;
                2: v = sample_en;
                default: v = offs_en;
            endcase
            if (v === lv) begin
                break;
            end
            @(negedge clock);
        end
        if (cnt >= lim) begin
            n_mismatch++;
            $display("FAIL at %0t seen %h expected %h", $time, ~lv, lv);
            results();
        end
    endtask : wait_sig

    initial begin
        clock = 1'h0;
        rst_n = 1'h0;
        vin = 13'h0000;
        comp_high = 1'h0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (16) @(negedge clock);
        chk(ready_flag, 1'h0);
        chk(done_n, 1'h1);
        chk(bus_oe_n, OE_OFF);
        chk(trim, CORR_RST);
        rst_n = 1'h1;
        t0 = $time;
        repeat (200) @(negedge clock);
        sarseq_host_model_i.drive(5'h0d, 6);
        chk(bus_oe_n, ~TEST_MASK);
        sarseq_host_model_i.drive(HOST_IDLE, 3);
        chk(bus_oe_n, OE_OFF);
        sarseq_host_model_i.start(1'h1);
        repeat (60) @(negedge clock);
        chk(sample_en, 1'h0);
        chk(ready_flag, 1'h0);
        wait_sig(0, 1'h1, 36000, n);
        chk(in_rng(since(t0), 34850, 34930), 1'h1);
        tend("power-up calibration");
        vin = 13'h0123;
        sarseq_host_model_i.start(1'h1);
        wait_sig(1, 1'h0, 700, n);
        vin = 13'h1234;
        sarseq_host_model_i.start(1'h1);
        chk(done_n, 1'h1);
        wait_sig(0, 1'h0, 300, n);
        repeat (100) @(negedge clock);
        sarseq_host_model_i.drive(5'h07, 8);
        chk(sample_en, 1'h0);
        chk(ready_flag, 1'h1);
        // The calibration below is a separate request; this abort leaves the correction words as they were.
        tend("abort");
        t0 = $time;
        sarseq_host_model_i.cal_pulse();
        wait_sig(0, 1'h0, 5, n);
        repeat (1250) @(negedge clock);
        chk(offs_en, 1'h1);
        chk(lad_en, 1'h0);
        repeat (8750) @(negedge clock);
        chk(offs_en, 1'h0);
        chk(lad_en, 1'h1);
        wait_sig(0, 1'h1, 30000, n);
        chk(in_rng(since(t0), 34860, 34940), 1'h1);
        tend("calibration");
        for (int i = 0; i < 5; i++) begin
            vin = vals[i];
            sarseq_host_model_i.start(i[0] ? 1'h0 : 1'h1);
            if (i[0]) begin
                wait_sig(3, 1'h1, 10, n);
                wait_sig(3, 1'h0, 700, n);
                chk(in_rng(n, 620, 655), 1'h1);
            end
            wait_sig(2, 1'h1, 30, n);
            wait_sig(2, 1'h0, 200, n);
            chk(in_rng(n, 145, 178), 1'h1);
            repeat (2) @(negedge clock);
            chk(ready_flag, 1'h0);
            wait_sig(1, 1'h0, 400, n);
            chk(in_rng(n, 315, 330), 1'h1);
            chk(ready_flag, 1'h1);
            sarseq_host_model_i.read(d, ok);
            chk(ok, 1'h1);
            chk(d, vals[i]);
            chk(d[12], vals[i][12]);
            chk(done_n, 1'h1);
            repeat (3) @(negedge clock);
            chk(bus_oe_n, OE_OFF);
            tend("conversion");
        end
        vin = 13'h0555;
        sarseq_host_model_i.drive(5'h07, 8);
        sarseq_host_model_i.drive(5'h0f, 3);
        sarseq_host_model_i.drive(HOST_IDLE, 1);
        wait_sig(1, 1'h0, 700, n);
        chk(in_rng(n, 470, 505), 1'h1);
        sarseq_host_model_i.drive(5'h17, 5);
        sarseq_host_model_i.drive(HOST_IDLE, 60);
        chk(sample_en, 1'h0);
        chk(done_n, 1'h0);
        sarseq_host_model_i.drive(5'h1b, 6);
        chk(bus_oe_n, OE_OFF);
        chk(done_n, 1'h0);
        sarseq_host_model_i.drive(HOST_IDLE, 1);
        sarseq_host_model_i.read(d, ok);
        chk(d, 13'h0555);
        tend("chip select");
        results();
    end
endmodule : tb
